// ==== logic/gpio_ports_pkg.sv ====
// constants, request carrier and helpers shared by the bidirectional port block
// Function
// - port reads return live pin levels
// - any reset makes every pin an input
// - first port has four pins, upper bits zero
// - second port has eight bidirectional pins
// - third address is port or plain register
// - direction load copies working register to port
// - direction one floats pin, zero drives latch
// - direction bits write-only, all ones after reset
// - read shows low when pin held low
// - pin inputs are never latched for reads
// - output latches hold until rewritten
// - every pin has its own direction bit
// - bit set/clear rewrites all latches from pins
// - writes land at cycle end, reads sample start
package gpio_ports_pkg;

   // ---------------------------------------------------------------
   // file addresses and widths
   // ---------------------------------------------------------------
   localparam logic [6:0] FIRST_PORT_ADDR = 7'h05;
   localparam logic [6:0] SECOND_PORT_ADDR = 7'h06;
   localparam logic [6:0] THIRD_PORT_ADDR = 7'h07;
   localparam int FIRST_PORT_WIDTH = 4;
   localparam int WIDE_PORT_WIDTH = 8;
   localparam logic [7:0] DIRECTION_RESET = 8'hff;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // ---------------------------------------------------------------
   // one instruction-cycle request from the core
   // ---------------------------------------------------------------
   typedef struct packed {
      logic file_write;  // plain write of data to file addr
      logic file_read;   // read of file addr
      logic bit_op;      // bit set or bit clear instruction on addr
      logic bit_set;     // 1 = set, 0 = clear
      logic [2:0] bit_sel;
      logic dir_load;    // direction load instruction, addr names port
      logic [6:0] addr;
      logic [7:0] data;  // working register or write data
   } cpu_req_type;

   // levels seen by a read; unmapped addresses answer zero
   function automatic logic [7:0] port_read(input logic [6:0] a, input logic [3:0] la,
                                            input logic [7:0] lb, input logic [7:0] lc);
      logic [7:0] v;
      v = READ_IDLE;
      if (a == FIRST_PORT_ADDR) begin
         v = {4'h0, la};
      end else if (a == SECOND_PORT_ADDR) begin
         v = lb;
      end else if (a == THIRD_PORT_ADDR) begin
         v = lc;
      end
      return v;
   endfunction : port_read

   // one bit forced, the rest copied from the read value
   function automatic logic [7:0] bit_modify(input logic [7:0] v, input logic [2:0] b,
                                             input logic s);
      logic [7:0] r;
      r = v;
      r[b] = s;
      return r;
   endfunction : bit_modify

endpackage : gpio_ports_pkg

// ==== logic/port_pins.sv ====
// one port: output latches, drive enables and pin synchroniser
`timescale 1ns/10ps
`default_nettype none
module port_pins
   import gpio_ports_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_latch,
   input wire logic [WIDTH-1:0] latch_data,
   input wire logic wr_dir,
   input wire logic [WIDTH-1:0] dir_data,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] pin_level
);
   logic [WIDTH-1:0] pin_meta;

   // output latches carry no reset: contents survive warm resets
   // latch not reset
   always_ff @(posedge clk) begin
      if (wr_latch) begin
         pin_out <= latch_data;
      end
   end

   // drive enable is the inverse of the direction bit, per pin
   // direction to driver
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_oe <= ~DIRECTION_RESET[WIDTH-1:0];
      end else if (wr_dir) begin
         pin_oe <= ~dir_data;
      end
   end

   // two stages before any read logic; pins are asynchronous
   // pins never latched
   always_ff @(posedge clk) begin
      pin_meta <= pin_in;
      pin_level <= pin_meta;
   end
endmodule : port_pins
`default_nettype wire

// ==== logic/gpio_ports.sv ====
// bidirectional port block: register decode, read path and checks
`timescale 1ns/10ps
`default_nettype none
module gpio_ports
   import gpio_ports_pkg::*;
#(
   parameter bit HAS_THIRD_PORT = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire cpu_req_type req,
   output logic [7:0] rd_data,
   output logic rd_valid,
   input wire logic [3:0] first_port_in,
   output logic [3:0] first_port_out,
   output logic [3:0] first_port_oe,
   input wire logic [7:0] second_port_in,
   output logic [7:0] second_port_out,
   output logic [7:0] second_port_oe,
   input wire logic [7:0] third_port_in,
   output logic [7:0] third_port_out,
   output logic [7:0] third_port_oe
);
   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic [3:0] first_level;
   logic [7:0] second_level;
   logic [7:0] third_pins;
   logic [7:0] third_level;
   logic [7:0] read_now;
   logic [7:0] next_latch;
   logic latch_wr;
   logic hit_first;
   logic hit_second;
   logic hit_third;

   // without the third port the address is a plain register: read its store
   // port or register
   assign third_level = HAS_THIRD_PORT ? third_pins : third_port_out;

   assign hit_first = (req.addr == FIRST_PORT_ADDR);
   assign hit_second = (req.addr == SECOND_PORT_ADDR);
   assign hit_third = (req.addr == THIRD_PORT_ADDR);

   assign read_now = port_read(req.addr, first_level, second_level, third_level);

   // bit ops modify what the pins show, so output latches pick up pin levels
   // read modify write
   assign next_latch = req.bit_op ? bit_modify(read_now, req.bit_sel, req.bit_set) : req.data;
   assign latch_wr = req.file_write | req.bit_op;

   // ---------------------------------------------------------------
   // ports
   // ---------------------------------------------------------------
   // four low pins only
   port_pins #(.WIDTH(FIRST_PORT_WIDTH)) first_cell (
      .clk(clk),
      .rst(rst),
      .wr_latch(latch_wr & hit_first),
      .latch_data(next_latch[3:0]),
      .wr_dir(req.dir_load & hit_first),
      .dir_data(req.data[3:0]),
      .pin_in(first_port_in),
      .pin_out(first_port_out),
      .pin_oe(first_port_oe),
      .pin_level(first_level)
   );

   port_pins #(.WIDTH(WIDE_PORT_WIDTH)) second_cell (
      .clk(clk),
      .rst(rst),
      .wr_latch(latch_wr & hit_second),
      .latch_data(next_latch),
      .wr_dir(req.dir_load & hit_second),
      .dir_data(req.data),
      .pin_in(second_port_in),
      .pin_out(second_port_out),
      .pin_oe(second_port_oe),
      .pin_level(second_level)
   );

   // small variant never loads direction, so its drivers stay off
   // direction load
   port_pins #(.WIDTH(WIDE_PORT_WIDTH)) third_cell (
      .clk(clk),
      .rst(rst),
      .wr_latch(latch_wr & hit_third),
      .latch_data(next_latch),
      .wr_dir(req.dir_load & hit_third & HAS_THIRD_PORT),
      .dir_data(req.data),
      .pin_in(third_port_in),
      .pin_out(third_port_out),
      .pin_oe(third_port_oe),
      .pin_level(third_pins)
   );

   // ---------------------------------------------------------------
   // read answer
   // ---------------------------------------------------------------
   // read value captured at the request edge; direction bits never appear here
   // no direction readback
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data <= READ_IDLE;
      end else if (req.file_read) begin
         rd_data <= read_now;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= req.file_read;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_reset_all_inputs: assert property (
      @(posedge clk) rst |=> (first_port_oe == 4'h0) && (second_port_oe == 8'h00)
         && (third_port_oe == 8'h00))
      else $error("drivers not released after reset");

   a_read_second_pins: assert property (
      @(posedge clk) disable iff (rst) (req.file_read && hit_second)
         |=> rd_valid && (rd_data == $past(second_level)))
      else $error("second port read did not return pin levels");

   a_first_upper_zero: assert property (
      @(posedge clk) disable iff (rst) (req.file_read && hit_first)
         |=> rd_data[7:4] == 4'h0)
      else $error("first port upper bits not zero");

   a_dir_load_value: assert property (
      @(posedge clk) disable iff (rst) (req.dir_load && hit_second)
         |=> second_port_oe == ~$past(req.data))
      else $error("direction load did not follow working register");

   a_latch_holds: assert property (
      @(posedge clk) disable iff (rst) !(latch_wr && hit_second)
         |=> $stable(second_port_out))
      else $error("second port latch changed without a write");

   a_write_input_pin: assert property (
      @(posedge clk) disable iff (rst) (req.file_write && !req.bit_op && hit_second)
         |=> second_port_out == $past(req.data))
      else $error("port write lost");

   a_rmw_from_pins: assert property (
      @(posedge clk) disable iff (rst) (req.bit_op && !req.file_write && hit_second)
         |=> second_port_out == bit_modify($past(second_level), $past(req.bit_sel),
            $past(req.bit_set)))
      else $error("bit op did not rewrite latches from pins");

   a_third_as_register: assert property (
      @(posedge clk) disable iff (rst) !HAS_THIRD_PORT |-> third_port_oe == 8'h00)
      else $error("third address drives pins in small variant");

   a_read_pulse_once: assert property (
      @(posedge clk) disable iff (rst) !req.file_read |=> !rd_valid)
      else $error("read answer without a read");

   // ---------------------------------------------------------------
   // read path, direction and write checks
   // ---------------------------------------------------------------
   // the answer pulse follows every read by exactly one cycle
   a_read_answer_due: assert property (
      @(posedge clk) disable iff (rst) req.file_read |=> rd_valid)
      else $error("read answer missing");

   // the answer word stays put between reads
   a_read_data_holds: assert property (
      @(posedge clk) disable iff (rst) !req.file_read |=> $stable(rd_data))
      else $error("read answer changed without a read");

   // first port answers its synchronised pins in the low nibble
   a_read_first_pins: assert property (
      @(posedge clk) disable iff (rst) (req.file_read && hit_first)
         |=> rd_data == {4'h0, $past(first_level)})
      else $error("first port read did not return pin levels");

   // large variant reads the third pins, small variant reads its store
   a_read_third_pins: assert property (
      @(posedge clk) disable iff (rst) (HAS_THIRD_PORT && req.file_read && hit_third)
         |=> rd_data == $past(third_pins))
      else $error("third port read did not return pin levels");

   a_read_third_store: assert property (
      @(posedge clk) disable iff (rst) (!HAS_THIRD_PORT && req.file_read && hit_third)
         |=> rd_data == $past(third_port_out))
      else $error("third address read did not return its store");

   // no address answers with direction bits; unmapped reads give zero
   a_unmapped_read_zero: assert property (
      @(posedge clk) disable iff (rst)
         (req.file_read && !hit_first && !hit_second && !hit_third)
         |=> rd_data == READ_IDLE)
      else $error("unmapped read not zero");

   // each first port pin follows its own direction bit
   a_first_dir_load: assert property (
      @(posedge clk) disable iff (rst) (req.dir_load && hit_first)
         |=> first_port_oe == ~$past(req.data[3:0]))
      else $error("first port direction load lost");

   // direction bits move only on a direction load
   a_dir_holds: assert property (
      @(posedge clk) disable iff (rst) !(req.dir_load && hit_second)
         |=> $stable(second_port_oe))
      else $error("second port direction changed without a load");

   // a write to the first port lands in its four latches
   a_first_write_lands: assert property (
      @(posedge clk) disable iff (rst) (req.file_write && !req.bit_op && hit_first)
         |=> first_port_out == $past(req.data[3:0]))
      else $error("first port write lost");
endmodule : gpio_ports
`default_nettype wire

// ==== tb/board_model.sv ====
// board circuitry on one port: pull-ups and an optional external driver
`timescale 1ns/10ps
`default_nettype none
module board_model #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] pin_out,
   input wire logic [WIDTH-1:0] pin_oe,
   input wire logic [WIDTH-1:0] ext_en,
   input wire logic [WIDTH-1:0] ext_val,
   output logic [WIDTH-1:0] pin_level
);
   // -----------------------------------------
   // wire level
   // -----------------------------------------
   // drive only when told
   // the external source wins, as a strong clamp would; released pins sit at the pull-up
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         pin_level[i] = ext_en[i] ? ext_val[i] : (pin_oe[i] ? pin_out[i] : 1'b1);
      end
   end
endmodule : board_model
`default_nettype wire

// ==== tb/bidirectional_io_ports_bench.sv ====
// self-checking bench for the bidirectional port block
`timescale 1ns/10ps
`default_nettype none
module bidirectional_io_ports_bench;
   import gpio_ports_pkg::*;
   logic clk, rst, rd_valid;
   cpu_req_type req;
   logic [7:0] rd_data, bi, bo, boe, ci, co, coe, xb_en, xb_val, xc_en, xc_val;
   logic [3:0] ai, ao, aoe, xa_en, xa_val;
   logic [7:0] exp_q[$];
   logic [7:0] d, w, b;
   logic [7:0] rd_s, co_s, coe_s;
   logic [31:0] seed = 32'h59;
   int fail_count = 0, samples_checked = 0, cycles = 0;

   gpio_ports i_dut (.clk(clk), .rst(rst), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
      .first_port_in(ai), .first_port_out(ao), .first_port_oe(aoe),
      .second_port_in(bi), .second_port_out(bo), .second_port_oe(boe),
      .third_port_in(ci), .third_port_out(co), .third_port_oe(coe));
   // small variant: its third address is a plain store, its third pins get inverted levels
   gpio_ports #(.HAS_THIRD_PORT(1'b0)) i_small (.clk(clk), .rst(rst), .req(req),
      .rd_data(rd_s), .rd_valid(), .first_port_in(ai), .first_port_out(), .first_port_oe(),
      .second_port_in(bi), .second_port_out(), .second_port_oe(),
      .third_port_in(~ci), .third_port_out(co_s), .third_port_oe(coe_s));
   board_model #(.WIDTH(4)) i_ba (.pin_out(ao), .pin_oe(aoe), .ext_en(xa_en),
      .ext_val(xa_val), .pin_level(ai));
   board_model i_bb (.pin_out(bo), .pin_oe(boe), .ext_en(xb_en), .ext_val(xb_val), .pin_level(bi));
   board_model i_bc (.pin_out(co), .pin_oe(coe), .ext_en(xc_en), .ext_val(xc_val), .pin_level(ci));

   // -----------------------------------------
   // helpers
   // -----------------------------------------
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : xs
   task automatic give_verdict();
      if (fail_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   task automatic check_pin(input logic [7:0] got, input logic [7:0] e);
      samples_checked++;
      if (got !== e) begin
         fail_count++;
         $display("wrong value at %0t: port %h expected %h", $time, got, e);
      end
   endtask : check_pin
   task automatic check_read(input logic [7:0] e);
      samples_checked++;
      if (rd_data !== e) begin
         fail_count++;
         $display("wrong value at %0t: read %h expected %h", $time, rd_data, e);
      end
   endtask : check_read
   // kind is {write, read, bit op, bit set}; requests change only at the falling edge
   task automatic op(input logic [3:0] k, input logic [2:0] s, input logic dl,
                     input logic [6:0] a, input logic [7:0] v);
      req = {k, s, dl, a, v};
      @(negedge clk);
   endtask : op
   task automatic idle(input int n);
      req = '0;
      repeat (n) @(negedge clk);
   endtask : idle
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      op(4'h4, 3'h0, 1'b0, a, 8'h00);
   endtask : rd

   // -----------------------------------------
   // clock, timeout and read monitor
   // -----------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         give_verdict();
      end
   end
   // a pulse with nothing noted is itself a mismatch
   always @(negedge clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) check_read(8'hxx);
         else check_read(exp_q.pop_front());
      end
   end

   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial begin
      req = '0; rst = 1'b1; xa_en = '0; xa_val = '0;
      xb_en = '0; xb_val = '0; xc_en = '0; xc_val = '0;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      check_pin({4'h0, aoe}, 8'h00);
      check_pin(boe, 8'h00);
      check_pin(coe, 8'h00);
      for (int n = 0; n < 4; n++) begin
         d = xs(); w = xs(); b = xs();
         xb_en = 8'hff; xb_val = b;
         op(4'h8, 3'h0, 1'b0, SECOND_PORT_ADDR, d);
         check_pin(bo, d);
         idle(3);
         rd(SECOND_PORT_ADDR, b);
         xb_val = ~b;
         idle(3);
         rd(SECOND_PORT_ADDR, ~b);
         // board lets go of the pins before the block starts driving them
         xb_en = w;
         op(4'h0, 3'h0, 1'b1, SECOND_PORT_ADDR, w);
         check_pin(boe, ~w);
         idle(3);
         rd(SECOND_PORT_ADDR, (d & ~w) | (~b & w));
         op(4'h0, 3'h0, 1'b1, SECOND_PORT_ADDR, 8'hff);
      end
      xb_en = '0;
      op(4'h0, 3'h0, 1'b1, SECOND_PORT_ADDR, 8'h00);
      op(4'h8, 3'h0, 1'b0, SECOND_PORT_ADDR, 8'hff);
      xb_en = 8'hff; xb_val = 8'h00;
      idle(3);
      rd(SECOND_PORT_ADDR, 8'h00);
      check_pin(bo, 8'hff);
      xb_en = '0;
      op(4'h0, 3'h0, 1'b1, SECOND_PORT_ADDR, 8'hf0);
      op(4'h8, 3'h0, 1'b0, SECOND_PORT_ADDR, 8'h00);
      xb_en = 8'hf0; xb_val = 8'ha0;
      idle(3);
      op(4'h3, 3'h1, 1'b0, SECOND_PORT_ADDR, 8'h00);
      check_pin(bo, 8'ha2);
      idle(3);
      op(4'h2, 3'h7, 1'b0, SECOND_PORT_ADDR, 8'h00);
      check_pin(bo, 8'h22);
      op(4'h0, 3'h0, 1'b1, FIRST_PORT_ADDR, 8'h00);
      op(4'h8, 3'h0, 1'b0, FIRST_PORT_ADDR, 8'hf5);
      check_pin({4'h0, ao}, 8'h05);
      idle(3);
      rd(FIRST_PORT_ADDR, 8'h05);
      d = xs();
      op(4'h0, 3'h0, 1'b1, THIRD_PORT_ADDR, 8'h00);
      op(4'h8, 3'h0, 1'b0, THIRD_PORT_ADDR, d);
      idle(3);
      rd(THIRD_PORT_ADDR, d);
      check_pin(rd_s, d);
      check_pin(co_s, d);
      check_pin(coe_s, 8'h00);
      rd(7'h08, 8'h00);
      idle(2);
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      check_pin(coe, 8'h00);
      check_pin(co, d);
      check_pin(8'(exp_q.size()), 8'h00);
      give_verdict();
   end
endmodule : bidirectional_io_ports_bench
`default_nettype wire
